// File: hw/wdog_reset_flag_map.vh
// Register map, field positions and timing counts of the watchdog block
`ifndef WDOG_RESET_FLAG_MAP_VH
`define WDOG_RESET_FLAG_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define WDOG_RESET_FLAG_ADDR_W          2
`define WDOG_RESET_FLAG_OFS_RSTSRC      2'h0
`define WDOG_RESET_FLAG_OFS_WDCTL       2'h1
`define WDOG_RESET_FLAG_OFS_KEY         2'h2

// ------------------------------------------------------------
// Reset source status fields
// ------------------------------------------------------------
`define WDOG_RESET_FLAG_RS_PON          0
`define WDOG_RESET_FLAG_RS_PIN          1
`define WDOG_RESET_FLAG_RS_BOR          2
`define WDOG_RESET_FLAG_RS_WDR          3
`define WDOG_RESET_FLAG_RS_POR_VALUE    4'h1

// ------------------------------------------------------------
// Watchdog control status fields
// ------------------------------------------------------------
`define WDOG_RESET_FLAG_WC_PS0          0
`define WDOG_RESET_FLAG_WC_PS2          2
`define WDOG_RESET_FLAG_WC_EN           3
`define WDOG_RESET_FLAG_WC_PS3          5
`define WDOG_RESET_FLAG_WC_IEN          6
`define WDOG_RESET_FLAG_WC_IFLAG        7
`define WDOG_RESET_FLAG_PS_RESET        4'h0
`define WDOG_RESET_FLAG_PS_MAX_VALID    4'h9

// ------------------------------------------------------------
// Unlock and timing
// ------------------------------------------------------------
`define WDOG_RESET_FLAG_KEY_VALUE       8'hd8
`define WDOG_RESET_FLAG_UNLOCK_CYCLES   3'h4
`define WDOG_RESET_FLAG_BASE_SHIFT      9
`define WDOG_RESET_FLAG_CNT_W           19

`endif

// File: hw/wdog_reset_flag_watchdog.v
// Watchdog timer with protected configuration and reset source flags
//
// Notes on behaviour
// - Lower level: disabled after reset, enable bit settable any time freely.
// - Lower level: disabling needs key write, then enable and period write within four.
// - Higher level: watchdog always runs; enable bit always reads one.
// - Higher level: period change needs key then write within four; enable ignored.
// - Watchdog reset flag bit 3: set on watchdog reset, cleared by POR or zero write.
// - Brown-out flag bit 2: set on brown-out, cleared by POR or zero write.
// - Pin reset flag bit 1: set on pin reset, cleared by POR or zero write.
// - Power-on flag bit 0: set by POR, cleared only by zero write.
// - Reset source bits 7:4 and control bit 4 read zero.
// - Interrupt flag bit 7 set on interrupt time-out; vector or one-write clears.
// - Interrupt request needs global enable, flag, and interrupt enable or the hold after its automatic clear.
// - With enable set, interrupt time-out clears interrupt enable; next gives reset.
// - Neither bit stops; irq enable interrupts; enable resets; both interrupt first.
// - Higher level: interrupt enable cannot be set; every time-out resets.
// - Enable bit 3 write one enables reset mode; zero disables if allowed.
// - Higher level: nothing, not even unlock, disables the watchdog.
// - Lower level: enable forced one while watchdog reset flag is set.
// - Four-bit period at bits 5,2:0; codes 0..9 give 512 to 256K cycles.
// - Reserved period codes 10..15 act as a valid code below ten.
// - Counter counts low-power oscillator cycles, not system clock.
// - Counter cleared by restart, while disabled, and on chip reset.
// - Fuse selects level: unprogrammed lower and off, programmed higher and on.
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "wdog_reset_flag_map.vh"

module wdog_reset_flag_watchdog
(
    clk,
    reset_n,
    regAddr,
    regWrData,
    regWrEn,
    regRdEn,
    regRdData,
    oscClkIn,
    alwaysOnFuse,
    powerOnEvent,
    pinResetEvent,
    brownoutEvent,
    wdogRestart,
    globalIrqEnable,
    irqVectorTaken,
    timeoutIrqReq,
    systemResetReq
);

    input  wire                       clk;
    input  wire                       reset_n;
    input  wire [`WDOG_RESET_FLAG_ADDR_W-1:0]    regAddr;
    input  wire [7:0]                 regWrData;
    input  wire                       regWrEn;
    input  wire                       regRdEn;
    output reg  [7:0]                 regRdData;
    input  wire                       oscClkIn;
    input  wire                       alwaysOnFuse;
    input  wire                       powerOnEvent;
    input  wire                       pinResetEvent;
    input  wire                       brownoutEvent;
    input  wire                       wdogRestart;
    input  wire                       globalIrqEnable;
    input  wire                       irqVectorTaken;
    output wire                       timeoutIrqReq;
    output reg                        systemResetReq;

    // ------------------------------------------------------------
    // Period code to time-out length
    // ------------------------------------------------------------
    function [`WDOG_RESET_FLAG_CNT_W-1:0] periodLimit;
        input [3:0] code;
        reg   [3:0] useCode;
        begin
            useCode = (code > `WDOG_RESET_FLAG_PS_MAX_VALID) ? `WDOG_RESET_FLAG_PS_MAX_VALID : code;
            periodLimit = {{(`WDOG_RESET_FLAG_CNT_W-1){1'b0}}, 1'b1} << (useCode + `WDOG_RESET_FLAG_BASE_SHIFT);
        end
    endfunction

    // ------------------------------------------------------------
    // Register address decode
    // ------------------------------------------------------------
    function addrHit;
        input [`WDOG_RESET_FLAG_ADDR_W-1:0] addr;
        input [`WDOG_RESET_FLAG_ADDR_W-1:0] target;
        begin
            addrHit = (addr == target);
        end
    endfunction

    // ------------------------------------------------------------
    // Control register read layout
    // ------------------------------------------------------------
    function [7:0] ctlWord;
        input       flag;
        input       irqEnable;
        input       enable;
        input [3:0] period;
        begin
            ctlWord = {flag, irqEnable, period[3], 1'b0, enable, period[2:0]};
        end
    endfunction

    // ------------------------------------------------------------
    // Period field of a control write
    // ------------------------------------------------------------
    function [3:0] periodField;
        input [7:0] data;
        begin
            periodField = {data[`WDOG_RESET_FLAG_WC_PS3], data[`WDOG_RESET_FLAG_WC_PS2:`WDOG_RESET_FLAG_WC_PS0]};
        end
    endfunction

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg  [4:0] syncA_reg;
    reg  [4:0] syncB_reg;
    reg        oscPrev_reg;

    always @(posedge clk)
    begin
        syncA_reg   <= {alwaysOnFuse, brownoutEvent, pinResetEvent, powerOnEvent, oscClkIn};
        syncB_reg   <= syncA_reg;
        oscPrev_reg <= syncB_reg[0];
    end

    wire oscTick    = syncB_reg[0] & ~oscPrev_reg;
    wire porSeen    = syncB_reg[1];
    wire pinSeen    = syncB_reg[2];
    wire borSeen    = syncB_reg[3];
    wire levelTwo   = syncB_reg[4];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    reg  [3:0]               rstFlags_reg;
    reg  [3:0]               rstFlags_next;
    reg                      enable_reg;
    reg                      enable_next;
    reg                      irqEn_reg;
    reg                      irqEn_next;
    reg                      irqFlag_reg;
    reg                      irqFlag_next;
    reg  [3:0]               period_reg;
    reg  [3:0]               period_next;
    reg  [2:0]               unlock_reg;
    reg  [2:0]               unlock_next;
    reg  [`WDOG_RESET_FLAG_CNT_W-1:0]   count_reg;
    reg  [`WDOG_RESET_FLAG_CNT_W-1:0]   count_next;
    reg                      sysRst_next;
    reg                      irqAuto_reg;
    reg                      irqAuto_next;
    reg  [7:0]               rdWord;
    localparam [`WDOG_RESET_FLAG_CNT_W-1:0] CNT_ONE = {{(`WDOG_RESET_FLAG_CNT_W-1){1'b0}}, 1'b1};

    wire       wrCtl     = regWrEn & addrHit(regAddr, `WDOG_RESET_FLAG_OFS_WDCTL);
    wire       wrRst     = regWrEn & addrHit(regAddr, `WDOG_RESET_FLAG_OFS_RSTSRC);
    wire       wrKey     = regWrEn & addrHit(regAddr, `WDOG_RESET_FLAG_OFS_KEY);
    wire       unlocked  = (unlock_reg != 3'h0);
    wire [3:0] wrPeriod  = periodField(regWrData);

    // Effective enable: forced by fuse or pending watchdog reset flag
    wire effEnable = levelTwo | enable_reg | rstFlags_reg[`WDOG_RESET_FLAG_RS_WDR];
    wire running   = effEnable | irqEn_reg;

    // ------------------------------------------------------------
    // Time-out decode
    // ------------------------------------------------------------
    wire [`WDOG_RESET_FLAG_CNT_W-1:0] lastCount = periodLimit(period_reg) - CNT_ONE;
    wire timeout   = running & oscTick & (count_reg == lastCount);
    wire toIrq     = timeout & irqEn_reg;
    wire toReset   = timeout & ~irqEn_reg & effEnable;

    // Request held after the automatic enable clear of a combined time-out
    assign timeoutIrqReq = irqFlag_reg & (irqEn_reg | irqAuto_reg)
                           & globalIrqEnable & ~levelTwo;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always @*
    begin
        rstFlags_next = rstFlags_reg;
        enable_next   = enable_reg;
        irqEn_next    = irqEn_reg;
        irqFlag_next  = irqFlag_reg;
        period_next   = period_reg;
        unlock_next   = unlocked ? unlock_reg - 3'h1 : 3'h0;
        count_next    = count_reg;
        sysRst_next   = 1'b0;
        irqAuto_next  = irqAuto_reg;

        // Reset source flags: zero write clears, events win
        if (wrRst)
        begin
            rstFlags_next = rstFlags_reg & regWrData[3:0];
        end
        if (pinSeen)
        begin
            rstFlags_next[`WDOG_RESET_FLAG_RS_PIN] = 1'b1;
        end
        if (borSeen)
        begin
            rstFlags_next[`WDOG_RESET_FLAG_RS_BOR] = 1'b1;
        end
        if (toReset)
        begin
            rstFlags_next[`WDOG_RESET_FLAG_RS_WDR] = 1'b1;
            sysRst_next = 1'b1;
        end
        if (porSeen)
        begin
            rstFlags_next = `WDOG_RESET_FLAG_RS_POR_VALUE;
        end

        // Unlock window
        if (wrKey && regWrData == `WDOG_RESET_FLAG_KEY_VALUE)
        begin
            unlock_next = `WDOG_RESET_FLAG_UNLOCK_CYCLES;
        end

        // Control register write
        if (wrCtl)
        begin
            if (regWrData[`WDOG_RESET_FLAG_WC_EN])
            begin
                enable_next = 1'b1;
            end
            else if (unlocked && !levelTwo)
            begin
                enable_next = 1'b0;
            end
            if (!levelTwo || unlocked)
            begin
                period_next = wrPeriod;
            end
            irqEn_next = regWrData[`WDOG_RESET_FLAG_WC_IEN] & ~levelTwo;
            if (regWrData[`WDOG_RESET_FLAG_WC_IFLAG])
            begin
                irqFlag_next = 1'b0;
            end
        end
        if (levelTwo)
        begin
            enable_next = 1'b1;
            irqEn_next  = 1'b0;
        end
        if (rstFlags_reg[`WDOG_RESET_FLAG_RS_WDR])
        begin
            enable_next = 1'b1;
        end

        // Interrupt flag: vector clears, time-out sets and wins
        if (irqVectorTaken)
        begin
            irqFlag_next = 1'b0;
        end
        if (toIrq)
        begin
            irqFlag_next = 1'b1;
            if (effEnable && !(wrCtl && regWrData[`WDOG_RESET_FLAG_WC_IEN]))
            begin
                irqEn_next   = 1'b0;
                irqAuto_next = 1'b1;
            end
        end
        if (!irqFlag_next)
        begin
            irqAuto_next = 1'b0;
        end

        // Counter
        if (!running || wdogRestart || timeout)
        begin
            count_next = {`WDOG_RESET_FLAG_CNT_W{1'b0}};
        end
        else if (oscTick)
        begin
            count_next = count_reg + {{(`WDOG_RESET_FLAG_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        rstFlags_reg <= rstFlags_next;
        if (!reset_n)
        begin
            enable_reg     <= 1'b0;
            irqEn_reg      <= 1'b0;
            irqFlag_reg    <= 1'b0;
            period_reg     <= `WDOG_RESET_FLAG_PS_RESET;
            unlock_reg     <= 3'h0;
            count_reg      <= {`WDOG_RESET_FLAG_CNT_W{1'b0}};
            systemResetReq <= 1'b0;
        end
        else
        begin
            enable_reg     <= enable_next;
            irqEn_reg      <= irqEn_next;
            irqFlag_reg    <= irqFlag_next;
            period_reg     <= period_next;
            unlock_reg     <= unlock_next;
            count_reg      <= count_next;
            systemResetReq <= sysRst_next;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            regRdData <= 8'h00;
        end
        else
        begin
            regRdData <= rdWord;
        end
    end

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    always @*
    begin
        rdWord = 8'h00;
        if (regRdEn)
        begin
            case (regAddr)
                `WDOG_RESET_FLAG_OFS_RSTSRC:
                begin
                    rdWord = {4'h0, rstFlags_reg};
                end
                `WDOG_RESET_FLAG_OFS_WDCTL:
                begin
                    rdWord = ctlWord(irqFlag_reg, irqEn_reg, effEnable, period_reg);
                end
                default:
                begin
                    rdWord = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt hold after automatic enable clear
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            irqAuto_reg <= 1'b0;
        end
        else
        begin
            irqAuto_reg <= irqAuto_next;
        end
    end

endmodule // wdog_reset_flag_watchdog

// File: tb/test_watchdog_with_reset_flags.sv
// Testbench for the watchdog block
`timescale 1ns/1ns
`include "wdog_reset_flag_map.vh"
module test_watchdog_with_reset_flags;
// --------
// Signals and instance
// --------
logic       clk = 0, reset_n = 0, regWrEn = 0, regRdEn = 0, oscClkIn = 0;
logic       alwaysOnFuse = 0, powerOnEvent = 1, pinResetEvent = 0, brownoutEvent = 0;
logic       wdogRestart = 0, globalIrqEnable = 0, irqVectorTaken = 0;
logic [1:0] regAddr = 0;
logic [7:0] regWrData = 0;
wire  [7:0] regRdData;
wire        timeoutIrqReq, systemResetReq;
int         miscompares = 0, checks_done = 0, rstSeen = 0, n, k;
always #4 clk = ~clk;
always #21 oscClkIn = ~oscClkIn;
always @(posedge clk) if (systemResetReq === 1'b1) rstSeen++;
wdog_reset_flag_watchdog dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .oscClkIn(oscClkIn),
    .alwaysOnFuse(alwaysOnFuse), .powerOnEvent(powerOnEvent), .pinResetEvent(pinResetEvent),
    .brownoutEvent(brownoutEvent), .wdogRestart(wdogRestart),
    .globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken),
    .timeoutIrqReq(timeoutIrqReq), .systemResetReq(systemResetReq));
// --------
// Tasks
// --------
task stop_test;
    if (miscompares == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
        $display("Error %s expected %h seen %h", nm, e, g);
        miscompares++;
    end
endtask
task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk);
    regWrEn <= 1'b0;
endtask
task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 chk("regRdData", e, regRdData);
endtask
task unl;
    wr(`WDOG_RESET_FLAG_OFS_KEY, `WDOG_RESET_FLAG_KEY_VALUE);
endtask
task rs;
    @(posedge clk);
    wdogRestart <= 1'b1;
    @(posedge clk);
    wdogRestart <= 1'b0;
endtask
task ev(input logic [2:0] m);
    {brownoutEvent, pinResetEvent, powerOnEvent} <= m;
    repeat (4) @(posedge clk);
    {brownoutEvent, pinResetEvent, powerOnEvent} <= 3'h0;
    repeat (4) @(posedge clk);
endtask
task wt(input logic r);
    n = 0;
    while ((r ? systemResetReq : timeoutIrqReq) !== 1'b1 && n < 4000)
    begin
        @(posedge clk);
        #1 n++;
    end
    chk("timeoutCycles", 8'h01, {7'h0, n >= 2600 && n < 2760});
endtask
// --------
// Sequence
// --------
initial
begin
    #400000 miscompares++;
    stop_test;
end
initial
begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    powerOnEvent <= 1'b0;
    repeat (3) @(posedge clk);
    rd(0, 8'h01);
    rd(1, 8'h00);
    ev(3'b010);
    rd(0, 8'h03);
    ev(3'b100);
    rd(0, 8'h07);
    wr(0, 8'hf0);
    rd(0, 8'h00);
    ev(3'b110);
    ev(3'b001);
    rd(0, 8'h01);
    wr(3, 8'hff);
    rd(3, 8'h00);
    for (int c = 0; c < 10; c++)
    begin
        wr(1, {2'b00, c[3], 2'b00, c[2:0]});
        rd(1, {2'b00, c[3], 2'b00, c[2:0]});
    end
    globalIrqEnable <= 1'b1;
    wr(1, 8'h40);
    rs;
    wt(0);
    rd(1, 8'hc0);
    globalIrqEnable <= 1'b0;
    #1 chk("timeoutIrqReq", 8'h00, {7'h0, timeoutIrqReq});
    globalIrqEnable <= 1'b1;
    @(posedge clk);
    irqVectorTaken <= 1'b1;
    @(posedge clk);
    irqVectorTaken <= 1'b0;
    rd(1, 8'h40);
    wt(0);
    wr(1, 8'hc0);
    rd(1, 8'h40);
    chk("rstSeen", 8'h00, rstSeen[7:0]);
    wr(1, 8'h48);
    rs;
    wt(0);
    rd(1, 8'h88);
    wr(1, 8'h88);
    rd(1, 8'h08);
    wt(1);
    rd(0, 8'h09);
    unl;
    wr(1, 8'h00);
    rd(1, 8'h08);
    wr(0, 8'h01);
    wr(1, 8'h00);
    rd(1, 8'h08);
    unl;
    repeat (5) @(posedge clk);
    wr(1, 8'h00);
    rd(1, 8'h08);
    unl;
    wr(1, 8'h00);
    rd(1, 8'h00);
    wr(1, 8'h08);
    rd(1, 8'h08);
    unl;
    wr(1, 8'h00);
    alwaysOnFuse <= 1'b1;
    repeat (6) @(posedge clk);
    rd(1, 8'h08);
    wr(1, 8'h40);
    rd(1, 8'h08);
    unl;
    wr(1, 8'h01);
    rd(1, 8'h09);
    wr(1, 8'h00);
    rd(1, 8'h09);
    unl;
    wr(1, 8'h00);
    rd(1, 8'h08);
    k = rstSeen;
    repeat (5)
    begin
        repeat (2000) @(posedge clk);
        rs;
    end
    chk("rstSeen", k[7:0], rstSeen[7:0]);
    wt(1);
    stop_test;
end
endmodule // test_watchdog_with_reset_flags

// File: tb/wdog_reset_flag_watchdog_chk.sv
// Port checker for the watchdog block
`timescale 1ns/1ns
`include "wdog_reset_flag_map.vh"
module wdog_reset_flag_watchdog_chk
(
    input logic                    clk,
    input logic                    reset_n,
    input logic [`WDOG_RESET_FLAG_ADDR_W-1:0] regAddr,
    input logic                    regRdEn,
    input logic [7:0]              regRdData,
    input logic                    alwaysOnFuse,
    input logic                    globalIrqEnable,
    input logic                    irqVectorTaken,
    input logic                    timeoutIrqReq,
    input logic                    systemResetReq
);
// --------
// Read tracking and properties
// --------
logic rdAny_reg, rdRs_reg, rdCtl_reg;
always_ff @(posedge clk)
begin
    rdAny_reg <= regRdEn;
    rdRs_reg  <= regRdEn && regAddr == `WDOG_RESET_FLAG_OFS_RSTSRC;
    rdCtl_reg <= regRdEn && regAddr == `WDOG_RESET_FLAG_OFS_WDCTL;
end
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n);
property p_rd_idle; !rdAny_reg |-> regRdData == 8'h00; endproperty
a_rd_idle: assert property (p_rd_idle) else $error("read data set outside read");
property p_rs_resv; rdRs_reg |-> regRdData[7:4] == 4'h0; endproperty
a_rs_resv: assert property (p_rs_resv) else $error("status upper bits set");
property p_ctl_resv; rdCtl_reg |-> !regRdData[4]; endproperty
a_ctl_resv: assert property (p_ctl_resv) else $error("control bit 4 set");
property p_gie; !globalIrqEnable |-> !timeoutIrqReq; endproperty
a_gie: assert property (p_gie) else $error("irq without global enable");
property p_rst_gap; systemResetReq |=> !systemResetReq [*8]; endproperty
a_rst_gap: assert property (p_rst_gap) else $error("reset pulse too long");
property p_lvl2_en;
    rdCtl_reg && alwaysOnFuse && $past(alwaysOnFuse, 6) |-> regRdData[3];
endproperty
a_lvl2_en: assert property (p_lvl2_en) else $error("enable reads zero");
property p_lvl2_ie;
    rdCtl_reg && alwaysOnFuse && $past(alwaysOnFuse, 6) |-> !regRdData[6];
endproperty
a_lvl2_ie: assert property (p_lvl2_ie) else $error("irq enable set");
property p_lvl2_irq; alwaysOnFuse && $past(alwaysOnFuse, 6) |-> !timeoutIrqReq; endproperty
a_lvl2_irq: assert property (p_lvl2_irq) else $error("irq at high level");
property p_vec_clr; irqVectorTaken |=> !timeoutIrqReq; endproperty
a_vec_clr: assert property (p_vec_clr) else $error("irq kept after vector");
c_rst: cover property (systemResetReq);
c_irq: cover property ($rose(timeoutIrqReq));
c_lvl2: cover property (rdCtl_reg && alwaysOnFuse && regRdData[3]);
endmodule // wdog_reset_flag_watchdog_chk
bind wdog_reset_flag_watchdog wdog_reset_flag_watchdog_chk chk (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
    .regRdEn(regRdEn), .regRdData(regRdData), .alwaysOnFuse(alwaysOnFuse),
    .globalIrqEnable(globalIrqEnable), .irqVectorTaken(irqVectorTaken),
    .timeoutIrqReq(timeoutIrqReq), .systemResetReq(systemResetReq));
